//--- core/rcf_pkg.sv
package rcf_pkg;

  // ****************************************************************
  // register map and bus widths
  // ****************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int MAC_W = 48;
  localparam int TX_FREE_W = 13;
  localparam logic [7:0] OFS_ADDR_FILTER = 8'h74;
  localparam logic [7:0] OFS_CSUM_BURST = 8'h76;
  localparam logic [7:0] OFS_TX_FREE = 8'h78;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_ACCEPT_BCAST = 7;
  localparam int BIT_ACCEPT_MCAST = 6;
  localparam int BIT_ACCEPT_UCAST = 5;
  localparam int BIT_ACCEPT_ALL = 4;
  localparam int BIT_RSVD_HI = 3;
  localparam int BIT_RSVD_LO = 2;
  localparam int BIT_INVERSE = 1;
  localparam int BIT_RX_RUN = 0;
  localparam int BURST_MSB = 7;
  localparam int BURST_LSB = 5;
  localparam int BIT_FRAG_BYPASS = 4;
  localparam int BIT_ZERO_PASS = 3;
  localparam int BIT_UDP_LITE = 2;
  localparam int BIT_ICMP_VERIFY = 1;
  localparam int BIT_OWN_SRC_DROP = 0;
  // the group bit is the first transmitted bit of the first octet
  localparam int BIT_DST_GROUP = 40;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_ADDR_FILTER = 16'h0000;
  localparam logic [15:0] RST_CSUM_BURST = 16'h0004;

  // ****************************************************************
  // receive queue read burst codes
  // ****************************************************************
  localparam logic [2:0] BURST_4B = 3'h0;
  localparam logic [2:0] BURST_8B = 3'h1;
  localparam logic [2:0] BURST_16B = 3'h2;
  localparam logic [2:0] BURST_32B = 3'h3;
  localparam logic [2:0] BURST_FRAME = 3'h4;

  typedef enum logic [1:0]
  {
    RCF_STOPPED = 2'b00,
    RCF_RUNNING = 2'b01,
    RCF_DRAINING = 2'b11
  } rcf_run_t;

endpackage

//--- core/rcf_cfg_if.sv
`timescale 1ns/1ps
interface rcf_cfg_if;
  logic acceptBcast;
  logic acceptMcast;
  logic acceptUcast;
  logic acceptAll;
  logic inverseFilter;
  logic fragBypass;
  logic zeroPass;
  logic udpLiteOn;
  logic icmpVerify;
  logic ownSrcDrop;
  logic framePass;

  modport ctrl
  (
    output acceptBcast, acceptMcast, acceptUcast, acceptAll, inverseFilter,
    output fragBypass, zeroPass, udpLiteOn, icmpVerify, ownSrcDrop,
    input framePass
  );
  modport filt
  (
    input acceptBcast, acceptMcast, acceptUcast, acceptAll, inverseFilter,
    input fragBypass, zeroPass, udpLiteOn, icmpVerify, ownSrcDrop,
    output framePass
  );
endinterface

//--- core/rcf_frame_filter.sv
`timescale 1ns/1ps
module rcf_frame_filter
(
  rcf_cfg_if.filt cfg,
  input wire logic [rcf_pkg::MAC_W-1:0] stationAddr,
  input wire logic [rcf_pkg::MAC_W-1:0] dstAddr,
  input wire logic [rcf_pkg::MAC_W-1:0] srcAddr,
  input wire logic isUdp,
  input wire logic isUdpLite,
  input wire logic isIcmp,
  input wire logic isFragment,
  input wire logic udpCsumZero,
  input wire logic udpCsumBad,
  input wire logic icmpCsumBad
);

  function automatic logic addrMatch(input logic [rcf_pkg::MAC_W-1:0] a,
                                     input logic [rcf_pkg::MAC_W-1:0] b);
    addrMatch = (a == b);
  endfunction

  logic isBcast;
  logic isMcast;
  logic normalHit;
  logic addrPass;
  logic udpDrop;
  logic liteDrop;
  logic icmpDrop;
  logic srcDrop;

  // ****************************************************************
  // destination address decision
  // ****************************************************************
  always_comb
  begin
    isBcast = &dstAddr;
    // broadcast has the group bit set, so multicast covers it
    isMcast = dstAddr[rcf_pkg::BIT_DST_GROUP];
    normalHit = (cfg.acceptMcast && isMcast) || // RULE_01
                (cfg.acceptBcast && isBcast) || // RULE_15
                (cfg.acceptUcast && !isMcast && addrMatch(dstAddr, stationAddr)); // RULE_02
    if (cfg.acceptAll)
    begin
      addrPass = 1'b1; // RULE_03
    end
    else
    begin
      addrPass = cfg.inverseFilter ? !normalHit : normalHit; // RULE_04
    end
  end

  // ****************************************************************
  // checksum and source policy
  // ****************************************************************
  always_comb
  begin
    // a zero udp checksum means "not computed", never a bad one
    udpDrop = isUdp && (udpCsumZero ? !cfg.zeroPass : // RULE_09
              (udpCsumBad && !(isFragment && cfg.fragBypass))); // RULE_08
    liteDrop = isUdpLite && cfg.udpLiteOn && udpCsumBad &&
               !(isFragment && cfg.fragBypass); // RULE_10
    icmpDrop = isIcmp && cfg.icmpVerify && !isFragment && icmpCsumBad; // RULE_11
    srcDrop = cfg.ownSrcDrop && addrMatch(srcAddr, stationAddr); // RULE_12
    cfg.framePass = addrPass && !udpDrop && !liteDrop && !icmpDrop && !srcDrop;
  end

endmodule

//--- core/rcf_rx_control.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - multicast-accept bit takes every multicast frame, broadcast included.
// RULE_02 - unicast-accept bit takes unicast frames matching the station address.
// RULE_03 - accept-all bit takes every frame whatever its destination.
// RULE_04 - inverse-filter bit reverses the destination address decision.
// RULE_05 - run bit starts receiving; clearing stops after the current frame.
// RULE_06 - write-only bits 7-5 choose receive queue read burst: 4,8,16,32,frame.
// RULE_07 - host sends a queue read command byte before every burst.
// RULE_08 - fragment bypass passes checksum check for fragmented udp frames.
// RULE_09 - zero udp checksum frames pass when bit set, dropped when clear.
// RULE_10 - udp-lite checksum check and generation, on after reset.
// RULE_11 - icmp verify drops non-fragmented icmp frames with bad checksum.
// RULE_12 - own-source drop discards frames sourced from the station address.
// RULE_13 - read-only bits 12-0 report free transmit queue bytes.
// RULE_14 - host checks free space covers the next frame before writing.
// RULE_15 - broadcast-accept bit takes every broadcast frame.
// RULE_16 - free count falls on host writes, rises when frames release space.
// RULE_17 - reserved burst codes are ignored; the previous code stays.
module rcf_rx_control
#(
  parameter int TX_QUEUE_BYTES = 8191
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [rcf_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rcf_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [rcf_pkg::DATA_W-1:0] regRdData,
  input wire logic [rcf_pkg::MAC_W-1:0] stationAddr,
  input wire logic frameStart,
  input wire logic frameEnd,
  input wire logic [rcf_pkg::MAC_W-1:0] dstAddr,
  input wire logic [rcf_pkg::MAC_W-1:0] srcAddr,
  input wire logic isUdp,
  input wire logic isUdpLite,
  input wire logic isIcmp,
  input wire logic isFragment,
  input wire logic udpCsumZero,
  input wire logic udpCsumBad,
  input wire logic icmpCsumBad,
  output logic rxRunning,
  output logic frameAccept,
  output logic frameDrop,
  output logic [2:0] rxqBurstCode,
  output logic rxqBurstWhole,
  output logic udpLiteTxGen,
  input wire logic txqWrStrobe,
  input wire logic [rcf_pkg::TX_FREE_W-1:0] txqWrBytes,
  input wire logic txqRelStrobe,
  input wire logic [rcf_pkg::TX_FREE_W-1:0] txqRelBytes,
  output logic [rcf_pkg::TX_FREE_W-1:0] txFreeBytes
);

  localparam logic [rcf_pkg::TX_FREE_W:0] TX_MAX = (rcf_pkg::TX_FREE_W+1)'(TX_QUEUE_BYTES);

  if (TX_QUEUE_BYTES < 1 || TX_QUEUE_BYTES > (1 << rcf_pkg::TX_FREE_W) - 1)
  begin : g_bad_size
    $error("TX_QUEUE_BYTES does not fit the free-space field");
  end

  rcf_cfg_if cfg ();

  logic [15:0] addrFilter_r;
  logic [15:0] addrFilter_nxt;
  logic [4:0] csumCfg_r;
  logic [4:0] csumCfg_nxt;
  logic [2:0] burst_r;
  logic [2:0] burst_nxt;
  logic burstWhole_r;
  logic burstWhole_nxt;
  logic [rcf_pkg::DATA_W-1:0] rdData_r;
  logic [rcf_pkg::DATA_W-1:0] rdData_nxt;
  rcf_pkg::rcf_run_t state_r;
  rcf_pkg::rcf_run_t state_nxt;
  logic inFrame_r;
  logic inFrame_nxt;
  logic running_r;
  logic running_nxt;
  logic accept_r;
  logic accept_nxt;
  logic drop_r;
  logic drop_nxt;
  logic [rcf_pkg::TX_FREE_W-1:0] txFree_r;
  logic [rcf_pkg::TX_FREE_W-1:0] txFree_nxt;
  logic [rcf_pkg::TX_FREE_W:0] txSum;
  logic wrFilter;
  logic wrCsum;
  logic runBit;

  // ****************************************************************
  // register file
  // ****************************************************************
  assign wrFilter = regWrEn && (regAddr == rcf_pkg::OFS_ADDR_FILTER);
  assign wrCsum = regWrEn && (regAddr == rcf_pkg::OFS_CSUM_BURST);
  assign runBit = addrFilter_r[rcf_pkg::BIT_RX_RUN];

  always_comb
  begin
    addrFilter_nxt = addrFilter_r;
    csumCfg_nxt = csumCfg_r;
    burst_nxt = burst_r;
    rdData_nxt = rdData_r;
    if (wrFilter)
    begin
      // upper control bits live elsewhere; only the low byte is held here
      addrFilter_nxt = {8'h00, regWrData[7:0]};
    end
    if (wrCsum)
    begin
      csumCfg_nxt = regWrData[4:0];
      // a reserved code would leave the queue reader without a length
      if (regWrData[rcf_pkg::BURST_MSB:rcf_pkg::BURST_LSB] <= rcf_pkg::BURST_FRAME)
      begin
        burst_nxt = regWrData[rcf_pkg::BURST_MSB:rcf_pkg::BURST_LSB]; // RULE_06 RULE_17
      end
    end
    if (regRdEn)
    begin
      case (regAddr)
        rcf_pkg::OFS_ADDR_FILTER: rdData_nxt = addrFilter_r;
        // burst code is write-only and reads back as zero
        rcf_pkg::OFS_CSUM_BURST: rdData_nxt = {11'h000, csumCfg_r};
        rcf_pkg::OFS_TX_FREE: rdData_nxt = {3'h0, txFree_r}; // RULE_13
        default: rdData_nxt = 16'h0000;
      endcase
    end
    burstWhole_nxt = (burst_nxt == rcf_pkg::BURST_FRAME); // RULE_06
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addrFilter_r <= rcf_pkg::RST_ADDR_FILTER;
      csumCfg_r <= rcf_pkg::RST_CSUM_BURST[4:0]; // RULE_10
      burst_r <= rcf_pkg::BURST_4B;
      burstWhole_r <= 1'b0;
      rdData_r <= 16'h0000;
    end
    else
    begin
      addrFilter_r <= addrFilter_nxt;
      csumCfg_r <= csumCfg_nxt;
      burst_r <= burst_nxt;
      burstWhole_r <= burstWhole_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign cfg.acceptBcast = addrFilter_r[rcf_pkg::BIT_ACCEPT_BCAST];
  assign cfg.acceptMcast = addrFilter_r[rcf_pkg::BIT_ACCEPT_MCAST];
  assign cfg.acceptUcast = addrFilter_r[rcf_pkg::BIT_ACCEPT_UCAST];
  assign cfg.acceptAll = addrFilter_r[rcf_pkg::BIT_ACCEPT_ALL];
  assign cfg.inverseFilter = addrFilter_r[rcf_pkg::BIT_INVERSE];
  assign cfg.fragBypass = csumCfg_r[rcf_pkg::BIT_FRAG_BYPASS];
  assign cfg.zeroPass = csumCfg_r[rcf_pkg::BIT_ZERO_PASS];
  assign cfg.udpLiteOn = csumCfg_r[rcf_pkg::BIT_UDP_LITE];
  assign cfg.icmpVerify = csumCfg_r[rcf_pkg::BIT_ICMP_VERIFY];
  assign cfg.ownSrcDrop = csumCfg_r[rcf_pkg::BIT_OWN_SRC_DROP];

  rcf_frame_filter u_filter
  (
    .cfg(cfg.filt),
    .stationAddr(stationAddr),
    .dstAddr(dstAddr),
    .srcAddr(srcAddr),
    .isUdp(isUdp),
    .isUdpLite(isUdpLite),
    .isIcmp(isIcmp),
    .isFragment(isFragment),
    .udpCsumZero(udpCsumZero),
    .udpCsumBad(udpCsumBad),
    .icmpCsumBad(icmpCsumBad)
  );

  // ****************************************************************
  // receive run state and frame verdict
  // ****************************************************************
  always_comb
  begin
    state_nxt = state_r;
    inFrame_nxt = inFrame_r;
    case (state_r)
      rcf_pkg::RCF_STOPPED:
      begin
        if (runBit)
        begin
          state_nxt = rcf_pkg::RCF_RUNNING; // RULE_05
        end
      end
      rcf_pkg::RCF_RUNNING:
      begin
        if (!runBit)
        begin
          state_nxt = (inFrame_r && !frameEnd) ? rcf_pkg::RCF_DRAINING
                                                : rcf_pkg::RCF_STOPPED; // RULE_05
        end
      end
      rcf_pkg::RCF_DRAINING:
      begin
        if (runBit)
        begin
          state_nxt = rcf_pkg::RCF_RUNNING;
        end
        else if (frameEnd)
        begin
          state_nxt = rcf_pkg::RCF_STOPPED; // RULE_05
        end
      end
      default: state_nxt = rcf_pkg::RCF_STOPPED;
    endcase
    // only frames that begin while running are taken; a stopped receiver ignores starts
    if (frameEnd)
    begin
      inFrame_nxt = 1'b0;
    end
    else if (frameStart && state_r == rcf_pkg::RCF_RUNNING && runBit)
    begin
      inFrame_nxt = 1'b1;
    end
    running_nxt = (state_nxt != rcf_pkg::RCF_STOPPED);
    accept_nxt = frameEnd && inFrame_r && cfg.framePass;
    drop_nxt = frameEnd && inFrame_r && !cfg.framePass;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= rcf_pkg::RCF_STOPPED;
      inFrame_r <= 1'b0;
      running_r <= 1'b0;
      accept_r <= 1'b0;
      drop_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      inFrame_r <= inFrame_nxt;
      running_r <= running_nxt;
      accept_r <= accept_nxt;
      drop_r <= drop_nxt;
    end
  end

  // ****************************************************************
  // transmit queue free space
  // ****************************************************************
  always_comb
  begin
    // clamp both ends so a bookkeeping slip cannot wrap the count
    txSum = {1'b0, txFree_r};
    if (txqRelStrobe)
    begin
      txSum = txSum + {1'b0, txqRelBytes}; // RULE_16
    end
    if (txSum > TX_MAX)
    begin
      txSum = TX_MAX;
    end
    if (txqWrStrobe)
    begin
      txSum = (txSum > {1'b0, txqWrBytes}) ? txSum - {1'b0, txqWrBytes}
                                           : '0; // RULE_16
    end
    txFree_nxt = txSum[rcf_pkg::TX_FREE_W-1:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txFree_r <= TX_MAX[rcf_pkg::TX_FREE_W-1:0];
    end
    else
    begin
      txFree_r <= txFree_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign rxRunning = running_r;
  assign frameAccept = accept_r;
  assign frameDrop = drop_r;
  assign rxqBurstCode = burst_r;
  assign rxqBurstWhole = burstWhole_r;
  assign udpLiteTxGen = csumCfg_r[rcf_pkg::BIT_UDP_LITE];
  assign txFreeBytes = txFree_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic cleanEnd;
  assign cleanEnd = frameEnd && inFrame_r && !isUdp && !isUdpLite && !isIcmp &&
                    (srcAddr != stationAddr);

  sequence drainStart;
    state_r == rcf_pkg::RCF_RUNNING && inFrame_r && !runBit && !frameEnd;
  endsequence
  sequence drainDone;
    state_r == rcf_pkg::RCF_DRAINING && frameEnd && !runBit;
  endsequence

  mcast_accept_a: assert property (cleanEnd && cfg.acceptMcast && dstAddr[40] && // RULE_01
    !cfg.inverseFilter |=> frameAccept && !frameDrop)
    else $error("multicast frame not accepted");
  ucast_accept_a: assert property (cleanEnd && cfg.acceptUcast && !cfg.inverseFilter && // RULE_02
    !dstAddr[40] && dstAddr == stationAddr |=> frameAccept)
    else $error("own unicast frame not accepted");
  accept_all_a: assert property (cleanEnd && cfg.acceptAll |=> frameAccept) // RULE_03
    else $error("accept-all frame not accepted");
  inverse_filter_a: assert property (cleanEnd && cfg.inverseFilter && !cfg.acceptAll && // RULE_04
    cfg.acceptUcast && !dstAddr[40] && dstAddr == stationAddr |=> frameDrop)
    else $error("inverse filter accepted a matching frame");
  drain_hold_a: assert property (drainStart |=> rxRunning && // RULE_05
    state_r == rcf_pkg::RCF_DRAINING)
    else $error("receiver stopped inside a frame");
  drain_stop_a: assert property (drainDone |=> !rxRunning ##1 !rxRunning) // RULE_05
    else $error("receiver did not stop after the frame");
  burst_write_a: assert property (wrCsum && regWrData[7:5] <= 3'h4 |=> // RULE_06
    rxqBurstCode == $past(regWrData[7:5]) && rxqBurstWhole == (rxqBurstCode == 3'h4))
    else $error("burst code not taken");
  burst_reserved_a: assert property (wrCsum && regWrData[7:5] > 3'h4 |=> // RULE_17
    $stable(rxqBurstCode))
    else $error("reserved burst code changed the setting");
  zero_csum_a: assert property (frameEnd && inFrame_r && isUdp && udpCsumZero && // RULE_09
    !cfg.zeroPass |=> frameDrop && !frameAccept)
    else $error("zero checksum udp frame not dropped");
  icmp_check_a: assert property (frameEnd && inFrame_r && isIcmp && cfg.icmpVerify && // RULE_11
    !isFragment && icmpCsumBad |=> frameDrop)
    else $error("bad icmp frame not dropped");
  own_source_a: assert property (frameEnd && inFrame_r && cfg.ownSrcDrop && // RULE_12
    srcAddr == stationAddr |=> frameDrop)
    else $error("own source frame not dropped");
  tx_free_a: assert property (txqWrStrobe && !txqRelStrobe && txFreeBytes >= txqWrBytes |=> // RULE_16
    txFreeBytes == $past(txFreeBytes) - $past(txqWrBytes))
    else $error("free space not reduced by the write");

endmodule

//--- test/rcf_host_model.sv
`timescale 1ns/1ps
module rcf_host_model
(
  input wire logic clk,
  input wire logic [rcf_pkg::DATA_W-1:0] regRdData,
  output logic [rcf_pkg::ADDR_W-1:0] regAddr,
  output logic [rcf_pkg::DATA_W-1:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  output logic txqWrStrobe,
  output logic [rcf_pkg::TX_FREE_W-1:0] txqWrBytes,
  output logic txqRelStrobe,
  output logic [rcf_pkg::TX_FREE_W-1:0] txqRelBytes
);
  initial
  begin
    {regAddr, regWrData, regWrEn, regRdEn} = '0;
    {txqWrStrobe, txqWrBytes, txqRelStrobe, txqRelBytes} = '0;
  end

  // ****************************************************************
  // register access
  // ****************************************************************
  // released lines show the inverse, so a stale value never looks fresh
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  // one read strobe per burst stands for the command byte that must open it
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask

  // ****************************************************************
  // transmit queue traffic
  // ****************************************************************
  // release side stands in for the transmitter handing space back
  task automatic transmit_queue(input logic [12:0] w, input logic [12:0] r);
    logic [15:0] f;
    rd(rcf_pkg::OFS_TX_FREE, f);
    @(posedge clk);
    txqWrStrobe <= (w != 13'h0000) && (f[12:0] >= w);
    txqWrBytes <= w;
    txqRelStrobe <= (r != 13'h0000);
    txqRelBytes <= r;
    @(posedge clk);
    txqWrStrobe <= 1'b0;
    txqRelStrobe <= 1'b0;
    txqWrBytes <= ~w;
    txqRelBytes <= ~r;
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checksDone++; \
    if ((g) !== (e)) \
    begin \
      nFail++; \
      $display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end

module testbench;
  localparam int QB = 64;
  localparam logic [47:0] STA = 48'h0211_2233_4455;
  localparam logic [47:0] OTH = 48'h02AA_BBCC_DDEE;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [6:0] UDP = 7'h40;
  localparam logic [6:0] LITE = 7'h20;
  localparam logic [6:0] ICMP = 7'h10;
  localparam logic [6:0] FRAG = 7'h08;
  localparam logic [6:0] ZERO = 7'h04;
  localparam logic [6:0] UBAD = 7'h02;
  localparam logic [6:0] IBAD = 7'h01;
  localparam logic [7:0] AF = rcf_pkg::OFS_ADDR_FILTER;
  localparam logic [7:0] CB = rcf_pkg::OFS_CSUM_BURST;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, rdv;
  logic regWrEn, regRdEn, txqWrStrobe, txqRelStrobe;
  logic [12:0] txqWrBytes, txqRelBytes, txFreeBytes;
  logic frameStart = 1'b0;
  logic frameEnd = 1'b0;
  logic [47:0] dstAddr = '0;
  logic [47:0] srcAddr = '0;
  logic [6:0] flg = '0;
  logic rxRunning, frameAccept, frameDrop, rxqBurstWhole, udpLiteTxGen;
  logic [2:0] rxqBurstCode;
  int nFail = 0;
  int checksDone = 0;

  always #12.5 clk = ~clk;

  rcf_host_model host_u
  (
    .clk(clk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .txqWrStrobe(txqWrStrobe),
    .txqWrBytes(txqWrBytes), .txqRelStrobe(txqRelStrobe), .txqRelBytes(txqRelBytes)
  );

  rcf_rx_control #(.TX_QUEUE_BYTES(QB)) dut_u
  (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .stationAddr(STA), .frameStart(frameStart), .frameEnd(frameEnd),
    .dstAddr(dstAddr), .srcAddr(srcAddr), .isUdp(flg[6]), .isUdpLite(flg[5]),
    .isIcmp(flg[4]), .isFragment(flg[3]), .udpCsumZero(flg[2]),
    .udpCsumBad(flg[1]), .icmpCsumBad(flg[0]), .rxRunning(rxRunning),
    .frameAccept(frameAccept), .frameDrop(frameDrop), .rxqBurstCode(rxqBurstCode),
    .rxqBurstWhole(rxqBurstWhole), .udpLiteTxGen(udpLiteTxGen),
    .txqWrStrobe(txqWrStrobe), .txqWrBytes(txqWrBytes), .txqRelStrobe(txqRelStrobe),
    .txqRelBytes(txqRelBytes), .txFreeBytes(txFreeBytes)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    host_u.rd(a, rdv);
    `CHK(rdv, e)
  endtask

  // two idle edges let the run state and its output flop settle
  task automatic cfg(input logic [7:0] a, input logic [15:0] d);
    host_u.wr(a, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic f_start();
    @(posedge clk);
    frameStart <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
  endtask

  // e is {accept, drop}; 2'b00 means no verdict at all
  task automatic f_end(input logic [47:0] d, s, input logic [6:0] f, input logic [1:0] e);
    @(posedge clk);
    dstAddr <= d;
    srcAddr <= s;
    flg <= f;
    frameEnd <= 1'b1;
    @(posedge clk);
    frameEnd <= 1'b0;
    dstAddr <= ~d;
    srcAddr <= ~s;
    flg <= ~f;
    #1;
    `CHK({frameAccept, frameDrop}, e)
  endtask

  task automatic frm(input logic [47:0] d, s, input logic [6:0] f, input logic [1:0] e);
    f_start();
    f_end(d, s, f, e);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    `CHK(rxRunning, 1'b0)
    `CHK(udpLiteTxGen, 1'b1)
    rd_chk(AF, rcf_pkg::RST_ADDR_FILTER);
    rd_chk(CB, 16'h0004);
    rd_chk(rcf_pkg::OFS_TX_FREE, 16'h0040);
    rd_chk(8'h7A, 16'h0000);
  endtask

  task automatic t_burst();
    for (int c = 0; c < 5; c++)
    begin
      host_u.wr(CB, {8'h00, 3'(c), 5'h04});
      #1;
      `CHK(rxqBurstCode, 3'(c))
      `CHK(rxqBurstWhole, (c == 4))
      rd_chk(CB, 16'h0004);
    end
    host_u.wr(CB, 16'h00A4);
    #1;
    `CHK(rxqBurstCode, rcf_pkg::BURST_FRAME)
    host_u.wr(CB, 16'h0004);
  endtask

  task automatic t_addr();
    cfg(AF, 16'h0041);
    frm(MC, OTH, '0, 2'b10);
    frm(BC, OTH, '0, 2'b10);
    frm(STA, OTH, '0, 2'b01);
    cfg(AF, 16'h0021);
    frm(STA, OTH, '0, 2'b10);
    frm(OTH, OTH, '0, 2'b01);
    cfg(AF, 16'h0011);
    frm(OTH, OTH, '0, 2'b10);
    cfg(AF, 16'h0023);
    frm(STA, OTH, '0, 2'b01);
    frm(OTH, OTH, '0, 2'b10);
    cfg(AF, 16'hFF8D);
    rd_chk(AF, 16'h008D);
    frm(BC, OTH, '0, 2'b10);
    frm(MC, OTH, '0, 2'b01);
  endtask

  task automatic t_csum();
    cfg(AF, 16'h0011);
    frm(OTH, OTH, UDP | ZERO, 2'b01);
    frm(OTH, OTH, UDP | UBAD | FRAG, 2'b01);
    frm(OTH, OTH, LITE | UBAD, 2'b01);
    frm(OTH, OTH, ICMP | IBAD, 2'b10);
    frm(OTH, STA, '0, 2'b10);
    cfg(CB, 16'h001B);
    `CHK(udpLiteTxGen, 1'b0)
    rd_chk(CB, 16'h001B);
    frm(OTH, OTH, UDP | ZERO, 2'b10);
    frm(OTH, OTH, UDP | UBAD | FRAG, 2'b10);
    frm(OTH, OTH, UDP | UBAD, 2'b01);
    frm(OTH, OTH, LITE | UBAD, 2'b10);
    frm(OTH, OTH, ICMP | IBAD, 2'b01);
    frm(OTH, OTH, ICMP | IBAD | FRAG, 2'b10);
    frm(OTH, STA, '0, 2'b01);
    cfg(CB, 16'h0004);
  endtask

  task automatic t_run();
    f_start();
    host_u.wr(AF, 16'h0010);
    repeat (3) @(posedge clk);
    #1;
    `CHK(rxRunning, 1'b1)
    f_end(OTH, OTH, '0, 2'b10);
    `CHK(rxRunning, 1'b0)
    @(posedge clk);
    #1;
    `CHK(rxRunning, 1'b0)
    frm(OTH, OTH, '0, 2'b00);
    cfg(AF, 16'h0011);
    `CHK(rxRunning, 1'b1)
    host_u.wr(AF, 16'h0010);
    #1;
    `CHK(rxRunning, 1'b1)
    @(posedge clk);
    #1;
    `CHK(rxRunning, 1'b0)
  endtask

  task automatic t_tx();
    host_u.transmit_queue(13'h001E, 13'h0000);
    #1;
    `CHK(txFreeBytes, 13'h0022)
    host_u.transmit_queue(13'h0005, 13'h000A);
    #1;
    `CHK(txFreeBytes, 13'h0027)
    host_u.transmit_queue(13'h0000, 13'h003C);
    #1;
    `CHK(txFreeBytes, 13'h0040)
    host_u.wr(rcf_pkg::OFS_TX_FREE, 16'h0000);
    rd_chk(rcf_pkg::OFS_TX_FREE, 16'h0040);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // the whole run takes well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    nFail++;
    stop_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_burst();
    t_addr();
    t_csum();
    t_run();
    t_tx();
    stop_test();
  end
endmodule
